//--- pkg/ldc_pkg.sv
// Purpose: Shared constants and carriers for the level-one data cache
// Assumes: 32-bit byte addresses, 64-byte lines, two ways
// Notes:   Geometry is fixed; sets and line size are localparams
package ldc_pkg;
  localparam int ADDR_W     = 32;
  localparam int LINE_BYTES = 64;
  localparam int OFF_W      = 6;
  localparam int SETS       = 64;
  localparam int IDX_W      = 6;
  localparam int TAG_W      = ADDR_W - IDX_W - OFF_W;
  localparam int LINE_W     = LINE_BYTES * 8;
  localparam int WAYS       = 2;
  localparam int PORTS      = 2;
  localparam logic [IDX_W-1:0] IDX_ZERO = 6'h00;

  typedef logic [TAG_W-1:0] ldc_tag_t;
  typedef logic [IDX_W-1:0] ldc_idx_t;
  typedef logic [LINE_W-1:0] ldc_line_t;

  // Core read request
  typedef struct packed {
    logic                 valid;
    logic [ADDR_W-1:0]    addr;
  } ldc_rd_req_s;

  // Core read answer
  typedef struct packed {
    logic                 valid;
    logic                 hit;
    ldc_line_t            data;
  } ldc_rd_rsp_s;

  // Fill from level2_memory, cache hit or RAM path
  typedef struct packed {
    logic                 valid;
    logic [ADDR_W-1:0]    addr;
    ldc_line_t            data;
  } ldc_fill_s;

  // Snoop write from the level2 controller
  typedef struct packed {
    logic                 valid;
    logic [ADDR_W-1:0]    addr;
    ldc_line_t            data;
  } ldc_snoop_s;

  // Write-back of a dirty line
  typedef struct packed {
    logic                 valid;
    logic [ADDR_W-1:0]    addr;
    ldc_line_t            data;
  } ldc_wb_s;

  // Core write
  typedef struct packed {
    logic                 valid;
    logic [ADDR_W-1:0]    addr;
    logic [31:0]          data;
  } ldc_wr_s;
endpackage

//--- logic/ldc_lookup.sv
// Purpose: Tag compare of one address against both ways of a set
// Assumes: Tag and valid arrays presented per way
// Notes:   Pure combinational
`timescale 1ns/100ps
module ldc_lookup
  import ldc_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire ldc_tag_t          tag0,
  input  wire ldc_tag_t          tag1,
  input  wire logic              vld0,
  input  wire logic              vld1,
  output logic                   hit,
  output logic                   way
);
  logic [TAG_W-1:0] t;
  // Compare tag against each way
  always_comb begin
    t   = addr[ADDR_W-1 -: TAG_W];
    hit = (vld0 && tag0 == t) || (vld1 && tag1 == t);
    way = !(vld0 && tag0 == t);
  end
endmodule // ldc_lookup

//--- logic/ldc_cache.sv
// Purpose: Level-one data cache with fills, snoop writes and write-back
// Assumes: level2_memory delivers fills and snoops as whole lines
// Notes:   Snoop is held pending one cycle, then checked against the tag
`timescale 1ns/100ps
module ldc_cache
  import ldc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire ldc_rd_req_s [1:0] rd_req,
  output ldc_rd_rsp_s [1:0]      rd_rsp,
  input  wire ldc_fill_s [1:0]   fill,
  input  wire ldc_wr_s           wr,
  input  wire ldc_snoop_s        snoop,
  output logic                   snoop_ready,
  input  wire logic              wb_req,
  input  wire logic [ADDR_W-1:0] wb_addr,
  output ldc_wb_s                wb
);
  // All state in one struct
  typedef struct packed {
    logic [WAYS-1:0][SETS-1:0]   vld;
    logic [WAYS-1:0][SETS-1:0]   dirty;
    logic [SETS-1:0]             lru;
    ldc_tag_t [WAYS-1:0][SETS-1:0] tag;
    ldc_line_t [WAYS-1:0][SETS-1:0] data;
    logic                        sn_pend;
    logic                        sn_way;
    ldc_snoop_s                  sn;
    ldc_rd_rsp_s [1:0]           rsp;
    ldc_wb_s                     wb;
  } ldc_state_s;

  ldc_state_s st_q, st_d;

  function automatic ldc_idx_t idx_of(input logic [ADDR_W-1:0] a);
    idx_of = a[OFF_W +: IDX_W];
  endfunction
  function automatic ldc_tag_t tag_of(input logic [ADDR_W-1:0] a);
    tag_of = a[ADDR_W-1 -: TAG_W];
  endfunction

  logic [PORTS-1:0] rd_hit, rd_way;
  logic             sn_hit, sn_way_l, wb_hit, wb_way;
  logic             wr_hit, wr_way;

  // Per-port read lookups
  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : g_rd
      ldc_lookup u_rd (
        .addr (rd_req[g].addr),
        .tag0 (st_q.tag[0][idx_of(rd_req[g].addr)]),
        .tag1 (st_q.tag[1][idx_of(rd_req[g].addr)]),
        .vld0 (st_q.vld[0][idx_of(rd_req[g].addr)]),
        .vld1 (st_q.vld[1][idx_of(rd_req[g].addr)]),
        .hit  (rd_hit[g]),
        .way  (rd_way[g])
      );
    end
  endgenerate

  // Snoop lookup at arrival
  ldc_lookup u_sn (
    .addr (snoop.addr),
    .tag0 (st_q.tag[0][idx_of(snoop.addr)]),
    .tag1 (st_q.tag[1][idx_of(snoop.addr)]),
    .vld0 (st_q.vld[0][idx_of(snoop.addr)]),
    .vld1 (st_q.vld[1][idx_of(snoop.addr)]),
    .hit  (sn_hit),
    .way  (sn_way_l)
  );

  // Write-back lookup
  ldc_lookup u_wb (
    .addr (wb_addr),
    .tag0 (st_q.tag[0][idx_of(wb_addr)]),
    .tag1 (st_q.tag[1][idx_of(wb_addr)]),
    .vld0 (st_q.vld[0][idx_of(wb_addr)]),
    .vld1 (st_q.vld[1][idx_of(wb_addr)]),
    .hit  (wb_hit),
    .way  (wb_way)
  );

  // Core write lookup
  ldc_lookup u_wr (
    .addr (wr.addr),
    .tag0 (st_q.tag[0][idx_of(wr.addr)]),
    .tag1 (st_q.tag[1][idx_of(wr.addr)]),
    .vld0 (st_q.vld[0][idx_of(wr.addr)]),
    .vld1 (st_q.vld[1][idx_of(wr.addr)]),
    .hit  (wr_hit),
    .way  (wr_way)
  );

  // One snoop in flight at a time
  assign snoop_ready = !st_q.sn_pend;

  // Next-state logic
  always_comb begin
    ldc_idx_t  fi;
    ldc_idx_t  si;
    ldc_idx_t  ri;
    logic      fw;
    logic      victim_wb;
    ldc_line_t wl;
    fi        = IDX_ZERO;
    si        = IDX_ZERO;
    ri        = IDX_ZERO;
    fw        = 1'b0;
    victim_wb = 1'b0;
    wl        = '0;
    st_d      = st_q;
    st_d.wb.valid = 1'b0;
    // Read answers, one per port
    for (int p = 0; p < PORTS; p++) begin
      ri = idx_of(rd_req[p].addr);
      st_d.rsp[p].valid = rd_req[p].valid;
      st_d.rsp[p].hit   = rd_req[p].valid && rd_hit[p];
      st_d.rsp[p].data  = st_q.data[rd_way[p]][ri];
      if (rd_req[p].valid && rd_hit[p]) begin
        st_d.lru[ri] = !rd_way[p];
      end
    end
    // Core write marks line dirty, no write-through
    if (wr.valid && wr_hit) begin
      wl = st_q.data[wr_way][idx_of(wr.addr)];
      wl[{wr.addr[OFF_W-1:2], 5'h00} +: 32] = wr.data;
      st_d.data[wr_way][idx_of(wr.addr)]  = wl;
      st_d.dirty[wr_way][idx_of(wr.addr)] = 1'b1;
    end
    // Software write-back request
    if (wb_req && wb_hit && st_q.dirty[wb_way][idx_of(wb_addr)]) begin
      st_d.wb.valid = 1'b1;
      st_d.wb.addr  = wb_addr;
      st_d.wb.data  = st_q.data[wb_way][idx_of(wb_addr)];
      st_d.dirty[wb_way][idx_of(wb_addr)] = 1'b0;
    end
    // Commit pending snoop, only if tag still matches
    if (st_q.sn_pend) begin
      si = idx_of(st_q.sn.addr);
      if (st_q.vld[st_q.sn_way][si] &&
          st_q.tag[st_q.sn_way][si] == tag_of(st_q.sn.addr)) begin
        st_d.data[st_q.sn_way][si] = st_q.sn.data;
      end
      st_d.sn_pend = 1'b0;
    end
    // Accept new snoop when held line exists
    if (snoop.valid && snoop_ready && sn_hit) begin
      st_d.sn_pend = 1'b1;
      st_d.sn_way  = sn_way_l;
      st_d.sn      = snoop;
    end
    // Line fills, each into its own set or way
    for (int p = 0; p < PORTS; p++) begin
      if (fill[p].valid) begin
        fi = idx_of(fill[p].addr);
        fw = !st_q.vld[0][fi] ? 1'b0 : !st_q.vld[1][fi] ? 1'b1 : st_d.lru[fi];
        // Second fill into the same set takes the way the first one left
        if (p == 1 && fill[0].valid && idx_of(fill[0].addr) == fi) begin
          fw = st_d.lru[fi];
        end
        if (st_q.vld[fw][fi] && st_q.dirty[fw][fi] && !victim_wb) begin
          victim_wb     = 1'b1;
          st_d.wb.valid = 1'b1;
          st_d.wb.addr  = {st_q.tag[fw][fi], fi, {OFF_W{1'b0}}};
          st_d.wb.data  = st_q.data[fw][fi];
        end
        st_d.tag[fw][fi]   = tag_of(fill[p].addr);
        st_d.data[fw][fi]  = fill[p].data;
        st_d.vld[fw][fi]   = 1'b1;
        st_d.dirty[fw][fi] = 1'b0;
        st_d.lru[fi]       = !fw;
        // Kill a snoop aimed at the replaced line
        if (st_d.sn_pend && st_d.sn_way == fw && idx_of(st_d.sn.addr) == fi &&
            tag_of(st_d.sn.addr) != tag_of(fill[p].addr)) begin
          st_d.sn_pend = 1'b0;
        end
        if (st_q.sn_pend && st_q.sn_way == fw && si == fi &&
            tag_of(st_q.sn.addr) != tag_of(fill[p].addr)) begin
          st_d.data[fw][fi] = fill[p].data;
        end
      end
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_rsp = st_q.rsp;
  assign wb     = st_q.wb;
endmodule // ldc_cache

//--- dv/ldc_cache_sva.sv
// Purpose: Port checks for ldc_cache
// Assumes: Top ports only
// Notes:   Bound from the bench file
`timescale 1ns/100ps
module ldc_cache_sva
  import ldc_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire ldc_rd_req_s [1:0] rd_req,
  input wire ldc_rd_rsp_s [1:0] rd_rsp,
  input wire ldc_fill_s [1:0]   fill,
  input wire ldc_wr_s           wr,
  input wire ldc_snoop_s        snoop,
  input wire logic              snoop_ready,
  input wire logic              wb_req,
  input wire logic [ADDR_W-1:0] wb_addr,
  input wire ldc_wb_s           wb
);
  logic quiet;
  // No fill this cycle
  assign quiet = !fill[0].valid && !fill[1].valid;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Snoop taken, no fill in take or commit cycle
  sequence s_snoop_clear;
    snoop.valid && snoop_ready && quiet ##1 quiet;
  endsequence
  // Port 0 fill, then a read of that line
  sequence s_fill_read;
    fill[0].valid ##1 rd_req[0].valid && rd_req[0].addr == $past(fill[0].addr);
  endsequence
  a_rsp_port0:
    assert property (rd_req[0].valid |=> rd_rsp[0].valid) else $error("no answer 0");
  a_rsp_port1:
    assert property (rd_req[1].valid |=> rd_rsp[1].valid) else $error("no answer 1");
  a_rsp_unasked:
    assert property (!rd_req[0].valid |=> !rd_rsp[0].valid) else $error("stray answer");
  a_snoop_once:
    assert property (!snoop_ready |=> snoop_ready) else $error("snoop stuck");
  a_wb_source:
    assert property (wb.valid |-> $past(wb_req || !quiet)) else $error("stray write-back");
  a_wb_line:
    assert property (wb_req && quiet |=> !wb.valid || wb.addr[31:6] == $past(wb_addr[31:6]))
      else $error("wrong write-back line");
  a_fill_kept:
    assert property (s_fill_read |=> rd_rsp[0].hit && rd_rsp[0].data == $past(fill[0].data, 2))
      else $error("fill data lost");
  a_snoop_commit:
    assert property (s_snoop_clear ##1 rd_req[0].valid && rd_req[0].addr == $past(snoop.addr, 2)
      |=> !rd_rsp[0].hit || rd_rsp[0].data == $past(snoop.data, 3)) else $error("snoop lost");
endmodule // ldc_cache_sva

//--- dv/ldc_l2_model.sv
// Purpose: Level2 side, answers line requests with fills
// Assumes: Fill one cycle after request
// Notes:   Line content is the address repeated
`timescale 1ns/100ps
module ldc_l2_model
  import ldc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire ldc_rd_req_s [1:0] req,
  output ldc_fill_s [1:0]        fill
);
  // Both ports served in one cycle; idle data toggles
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      fill[i].valid <= req[i].valid;
      fill[i].addr  <= req[i].addr;
      fill[i].data  <= req[i].valid ? {16{req[i].addr}} : ~fill[i].data;
    end
  end
endmodule // ldc_l2_model

//--- dv/tb_ldc_cache.sv
// Purpose: Self-checking bench for ldc_cache
// Assumes: Inputs change at the falling edge
// Notes:   Fills come from ldc_l2_model
`timescale 1ns/100ps
module tb_ldc_cache
  import ldc_pkg::*;
;
  localparam logic [ADDR_W-1:0] P = 32'h1080;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  ldc_rd_req_s [1:0] rd_req = '0;
  ldc_rd_req_s [1:0] l2_req = '0;
  ldc_rd_rsp_s [1:0] rd_rsp;
  ldc_rd_rsp_s [1:0] r;
  ldc_fill_s [1:0]   fill;
  ldc_wr_s           wr = '0;
  ldc_snoop_s        snoop = '0;
  logic              snoop_ready;
  logic              wb_req = 1'b0;
  logic [ADDR_W-1:0] wb_addr = '0;
  ldc_wb_s           wb;
  int                bad_count = 0;
  int                comparisons = 0;
  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;
  ldc_l2_model i_ldc_l2_model (.core_clk(core_clk), .req(l2_req), .fill(fill));
  ldc_cache i_ldc_cache (.core_clk(core_clk), .rst(rst), .rd_req(rd_req), .rd_rsp(rd_rsp),
    .fill(fill), .wr(wr), .snoop(snoop), .snoop_ready(snoop_ready), .wb_req(wb_req),
    .wb_addr(wb_addr), .wb(wb));
  // Line served by the model
  function automatic ldc_line_t ln(input logic [ADDR_W-1:0] a);
    return {16{a}};
  endfunction
  // Compare and count
  task automatic chk(input logic [LINE_W-1:0] got, input logic [LINE_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: value differs", $time);
    end
  endtask
  // Fill through the model
  task automatic load(input logic [ADDR_W-1:0] a0, input logic v1, input logic [ADDR_W-1:0] a1);
    l2_req[0] = '{1'b1, a0};
    l2_req[1] = '{v1, a1};
    @(negedge core_clk);
    l2_req = '0;
    @(negedge core_clk);
  endtask
  // Two reads in one cycle
  task automatic rd(input logic [ADDR_W-1:0] a0, input logic [ADDR_W-1:0] a1);
    rd_req[0] = '{1'b1, a0};
    rd_req[1] = '{1'b1, a1};
    @(negedge core_clk);
    r = rd_rsp;
    rd_req = '0;
  endtask
  // Snoop write with inverted line
  task automatic snp(input logic [ADDR_W-1:0] a);
    snoop = '{1'b1, a, ~ln(a)};
    @(negedge core_clk);
    snoop = '0;
  endtask
  // Software write-back request
  task automatic wbq(output ldc_wb_s w);
    wb_req = 1'b1;
    wb_addr = P;
    @(negedge core_clk);
    w = wb;
    wb_req = 1'b0;
    @(negedge core_clk);
  endtask
  // Dual fill and read, then a third line in the set
  task automatic t_dual;
    load(32'h1040, 1'b1, 32'h2040);
    rd(32'h1040, 32'h2040);
    chk({r[0].valid, r[0].hit, r[1].valid, r[1].hit}, 4'hF);
    chk(r[0].data, ln(32'h1040));
    chk(r[1].data, ln(32'h2040));
    load(32'h3040, 1'b0, 32'h3040);
    rd(32'h1040, 32'h2040);
    chk(r[0].hit ^ r[1].hit, 1'b1);
  endtask
  // Snoop to a held line, then to a line not held
  task automatic t_snoop;
    load(P, 1'b1, 32'h2080);
    snp(P);
    chk(snoop_ready, 1'b0);
    @(negedge core_clk);
    rd(P, 32'h2080);
    chk(r[0].data, ~ln(P));
    chk(r[1].data, ln(32'h2080));
    snp(32'h3080);
    rd(32'h3080, P);
    chk(r[0].hit, 1'b0);
  endtask
  // Fill replaces a snooped line in the commit cycle, then in the take cycle
  task automatic t_cancel;
    load(32'h10C0, 1'b0, 32'h10C0);
    load(32'h20C0, 1'b0, 32'h20C0);
    l2_req[0] = '{1'b1, 32'h30C0};
    snp(32'h10C0);
    l2_req = '0;
    @(negedge core_clk);
    rd(32'h30C0, 32'h20C0);
    chk({r[0].hit, r[1].hit}, 2'b11);
    chk(r[0].data, ln(32'h30C0));
    l2_req[0] = '{1'b1, 32'h40C0};
    @(negedge core_clk);
    l2_req = '0;
    snp(32'h30C0);
    @(negedge core_clk);
    rd(32'h40C0, 32'h30C0);
    chk({r[0].hit, r[1].hit}, 2'b10);
    chk(r[0].data, ln(32'h40C0));
  endtask
  // Clean line stays, dirty line leaves once
  task automatic t_wb;
    ldc_wb_s   w;
    ldc_line_t x;
    ldc_line_t y;
    x = ~ln(P);
    x[95:64] = 32'hA5A5_0F0F;
    y = x;
    y[511:480] = 32'h5A5A_F0F0;
    wbq(w);
    chk(w.valid, 1'b0);
    wr = '{1'b1, P + 32'h8, 32'hA5A5_0F0F};
    @(negedge core_clk);
    wr = '0;
    wbq(w);
    chk(w.valid, 1'b1);
    chk(w.addr[31:6], P[31:6]);
    chk(w.data, x);
    wbq(w);
    chk(w.valid, 1'b0);
    // Dirty again, then two fills into the set evict it as a victim
    wr = '{1'b1, P + 32'h3C, 32'h5A5A_F0F0};
    @(negedge core_clk);
    wr = '0;
    load(32'h3080, 1'b1, 32'h4080);
    chk(wb.valid, 1'b1);
    chk(wb.addr, P);
    chk(wb.data, y);
  endtask
  // Counts and verdict
  task automatic results;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    t_dual();
    t_snoop();
    t_cancel();
    t_wb();
    results();
  end
  // Watchdog, tests need under 60 cycles
  initial begin
    #(25 * 300);
    bad_count++;
    results();
  end
endmodule // tb_ldc_cache
bind ldc_cache ldc_cache_sva i_ldc_cache_sva (.core_clk(core_clk), .rst(rst), .rd_req(rd_req),
  .rd_rsp(rd_rsp), .fill(fill), .wr(wr), .snoop(snoop), .snoop_ready(snoop_ready),
  .wb_req(wb_req), .wb_addr(wb_addr), .wb(wb));
